/* dv/dmr_checker_assertions.sv */
// port checker for the result block
// assumes bind to the design top, one clock
`timescale 1ns/100ps
module dmr_checker (
  input wire clk,
  input wire rst_b,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire manual_enable_mode,
  input wire battery_enable,
  input wire overvoltage_fault,
  input wire battery_short_fault,
  input wire overvoltage_fault_q,
  input wire battery_active_q,
  input wire battery_short_fault_q,
  input wire merge_overvoltage_into_battery_short_q,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wr_data,
  input wire [7:0] reg_rd_data_q,
  input wire [1:0] supply_monitor_filter_select_q,
  input wire [1:0] battery_monitor_filter_select_q
);
  // ==========
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire cw = reg_wr_en && reg_addr == 8'h54;
  wire mg = merge_overvoltage_into_battery_short_q;
  wire [1:0] sf = supply_monitor_filter_select_q;
  wire [1:0] bf = battery_monitor_filter_select_q;
  wire [1:0] flt = {overvoltage_fault, battery_short_fault};
  wire [1:0] fq = {overvoltage_fault_q, battery_short_fault_q};
  wire gate = !manual_enable_mode || battery_enable;
  wire id_rd = reg_rd_en && reg_addr inside {8'h57, 8'h59, 8'h5b, 8'h5d};
  a_sup_wr: assert property (cw |=> sf == $past(reg_wr_data[6:5]))
    else $error("sup");
  a_bat_wr: assert property (cw |=> bf == $past(reg_wr_data[3:2]))
    else $error("bat");
  a_cfg_hold: assert property (!cw |=> $stable({sf, bf, mg}))
    else $error("hold");
  a_fault_or: assert property (mg |=> fq == {1'b0, |$past(flt)})
    else $error("or");
  a_fault_split: assert property (!mg |=> fq == $past(flt))
    else $error("split");
  a_cfg_read: assert property (reg_rd_en && reg_addr == 8'h54 |=>
    reg_rd_data_q == {1'b0, $past(sf), 1'b0, $past(bf), 1'b0, $past(mg)}) else $error("cfg");
  a_source_id: assert property (id_rd |=>
    reg_rd_data_q[3:0] == {1'b0, $past(reg_addr[3:1])} - 4'h3) else $error("id");
  a_battery_gate: assert property (1'b1 |=> battery_active_q == $past(gate))
    else $error("gate");
  c_merge_wr: cover property (cw && reg_wr_data[0]);
  c_refused: cover property (!gate);
  c_id_rd: cover property (id_rd);
endmodule
bind dmr_diag_monitor_results dmr_checker dmr_checker_i (.*);

/* dv/tb_top.sv */
// bench: reads scored from a queue of expected values
// assumes the design top with the checker bound to it
`timescale 1ns/100ps
module tb_top;
  reg clk = 0, rst_b = 0, reg_wr_en = 0, reg_rd_en = 0, result_valid = 0, seen = 0;
  reg manual_enable_mode = 0, battery_enable = 0, overvoltage_fault = 0, battery_short_fault = 0;
  reg [7:0] reg_addr = 0, reg_wr_data = 0, cfg = 8'h48;
  reg [1:0] result_source = 0;
  reg [11:0] result_data = 0;
  reg [31:0] hi = 0;
  reg [15:0] lo = 0;
  wire [7:0] reg_rd_data_q;
  wire [1:0] supply_monitor_filter_select_q, battery_monitor_filter_select_q;
  wire merge_overvoltage_into_battery_short_q, overvoltage_fault_q, battery_short_fault_q;
  wire battery_active_q;
  wire [7:0] cfg_seen = {1'b0, supply_monitor_filter_select_q, 1'b0,
    battery_monitor_filter_select_q, 1'b0, merge_overvoltage_into_battery_short_q};
  integer bad_count = 0, checks_done = 0, k;
  reg [7:0] expq [$];
  dmr_diag_monitor_results dmr_diag_monitor_results_i (.*);
  // ==========
  // helpers
  task chk(input [7:0] s, input [7:0] e);
    checks_done = checks_done + 1;
    if (s !== e) begin
      bad_count = bad_count + 1;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask
  function [7:0] ev(input [7:0] a);
    reg [1:0] j;
    j = a[2:1] + 2'h1;
    ev = a[0] ? {lo[4 * j +: 4], 2'b00, j} : hi[8 * j +: 8];
    if (a < 8'h56 || a > 8'h5d) ev = (a == 8'h54) ? cfg : 8'h00;
  endfunction
  // software keeps reserved bits at zero on every write
  task bus(input w, input [7:0] a, input [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= w;
    reg_rd_en <= !w;
    if (w) cfg = d & 8'h6d;
    else expq.push_back(ev(a));
    @(posedge clk);
    reg_wr_en <= 0;
    reg_rd_en <= 0;
  endtask
  task res(input [1:0] s, input m, input b);
    @(posedge clk);
    result_source <= s;
    result_data <= 12'($urandom);
    result_valid <= 1;
    manual_enable_mode <= m;
    battery_enable <= b;
    @(posedge clk);
    result_valid <= 0;
    if (!m || b || s != 0) {hi[8 * s +: 8], lo[4 * s +: 4]} = result_data;
    @(negedge clk);
    chk({7'h00, battery_active_q}, {7'h00, !m || b});
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========
  // clock, watchdog, scoreboard
  initial forever #20 clk = ~clk;
  // about 170 cycles of tests, so 500 cycles is a hang
  initial begin #20000; bad_count = bad_count + 1; give_verdict; end
  always @(posedge clk) begin
    seen <= reg_rd_en;
    overvoltage_fault <= 1'($urandom);
    battery_short_fault <= 1'($urandom);
  end
  always @(negedge clk) if (seen) chk(reg_rd_data_q, expq.pop_front());
  // ==========
  // tests
  initial begin
    void'($urandom(32'hca5277aa));
    repeat (12) @(posedge clk);
    rst_b <= 1;
    for (k = 8'h54; k < 8'h5e; k++) bus(0, k[7:0], 0);
    $display("reset values done");
    for (k = 0; k < 4; k++) begin
      bus(1, 8'h54, {1'b0, k[1:0], 1'b0, ~k[1:0], 1'b0, k[0]});
      bus(0, 8'h54, 0);
      @(negedge clk);
      chk(cfg_seen, cfg);
    end
    $display("config done");
    for (k = 0; k < 16; k++) begin
      res(k[1:0], k[2], k[3]);
      bus(0, 8'h56 + {k[1:0], 1'b0}, 0);
      bus(0, 8'h57 + {k[1:0], 1'b0}, 0);
    end
    $display("results done");
    repeat (2) @(posedge clk);
    rst_b <= 0;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    cfg = 8'h48;
    hi = 0;
    lo = 0;
    for (k = 8'h54; k < 8'h5e; k++) bus(0, k[7:0], 0);
    $display("mid-run reset done");
    repeat (2) @(posedge clk);
    give_verdict;
  end
endmodule

/* hw/dmr_diag_monitor_results.v */
// register front end for the diagnostic converter results
// assumes converter results and fault flags arrive on clk; the
// manual-mode and battery-enable bits come from the neighbouring config
// Overview of operation
// (RULE1) supply filter select bits 6-5, reset 2
// (RULE2) battery filter select bits 3-2, reset 2
// (RULE3) bit 0 merges overvoltage into battery short
// (RULE4) result upper eight bits in high register
// (RULE5) result low nibble in bits 7-4 next
// (RULE6) low register bits 3-0 hold source id
// (RULE7) reserved bits 7,4,1 read zero, write zero
// (RULE8) negative input pin id is 3
// (RULE9) battery channel gated by enable in manual
// (RULE10) both halves updated together per conversion
`timescale 1ns/100ps
`include "dmr_defines.vh"
module dmr_diag_monitor_results (
  input wire clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wr_data,
  input wire reg_rd_en,
  output reg [7:0] reg_rd_data_q,
  input wire manual_enable_mode,
  input wire battery_enable,
  input wire [1:0] result_source,
  input wire result_valid,
  input wire [11:0] result_data,
  input wire overvoltage_fault,
  input wire battery_short_fault,
  output reg [1:0] supply_monitor_filter_select_q,
  output reg [1:0] battery_monitor_filter_select_q,
  output reg merge_overvoltage_into_battery_short_q,
  output reg overvoltage_fault_q,
  output reg battery_short_fault_q,
  output reg battery_active_q
);
  // ==========================================
  // local codes
  localparam [7:0] CFG_RESET = `DMR_CFG_RESET;
  localparam [1:0] SRC_BAT = 2'h0;
  localparam [1:0] SRC_BIAS = 2'h1;
  localparam [1:0] SRC_IN1P = 2'h2;
  localparam [1:0] SRC_IN1N = 2'h3;

  // ==========================================
  // write decode
  // only the configuration offset is writable; results ignore writes
  wire cfg_wr_hit;
  assign cfg_wr_hit = reg_wr_en && (reg_addr == `DMR_CFG_ADDR);

  // ==========================================
  // configuration register
  reg [1:0] supply_monitor_filter_select_d;
  reg [1:0] battery_monitor_filter_select_d;
  reg merge_overvoltage_into_battery_short_d;
  always @* begin
    supply_monitor_filter_select_d = supply_monitor_filter_select_q;
    battery_monitor_filter_select_d = battery_monitor_filter_select_q;
    merge_overvoltage_into_battery_short_d = merge_overvoltage_into_battery_short_q;
    if (cfg_wr_hit) begin
      // reserved positions are dropped, not stored
      supply_monitor_filter_select_d =
        reg_wr_data[`DMR_SUP_FILT_HI:`DMR_SUP_FILT_LO]; // see (RULE1)
      battery_monitor_filter_select_d =
        reg_wr_data[`DMR_BAT_FILT_HI:`DMR_BAT_FILT_LO]; // see (RULE2)
      merge_overvoltage_into_battery_short_d = reg_wr_data[`DMR_MERGE_BIT]; // see (RULE3)
    end
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      supply_monitor_filter_select_q <= CFG_RESET[`DMR_SUP_FILT_HI:`DMR_SUP_FILT_LO];
      battery_monitor_filter_select_q <= CFG_RESET[`DMR_BAT_FILT_HI:`DMR_BAT_FILT_LO];
      merge_overvoltage_into_battery_short_q <= CFG_RESET[`DMR_MERGE_BIT];
    end else begin
      supply_monitor_filter_select_q <= supply_monitor_filter_select_d;
      battery_monitor_filter_select_q <= battery_monitor_filter_select_d;
      merge_overvoltage_into_battery_short_q <= merge_overvoltage_into_battery_short_d;
    end
  end

  // ==========================================
  // configuration read image
  // reserved positions are tied low rather than stored
  wire [7:0] cfg_read;
  assign cfg_read = {
    1'b0,
    supply_monitor_filter_select_q,
    1'b0,
    battery_monitor_filter_select_q,
    1'b0,
    merge_overvoltage_into_battery_short_q
  }; // see (RULE7)

  // ==========================================
  // battery channel gating
  // auto mode leaves the battery channel on with the input diagnostics
  wire battery_active_d;
  assign battery_active_d = manual_enable_mode ? battery_enable : 1'b1; // see (RULE9)
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      battery_active_q <= 1'b0;
    end else begin
      battery_active_q <= battery_active_d;
    end
  end

  // ==========================================
  // fault reporting
  reg overvoltage_fault_d;
  reg battery_short_fault_d;
  always @* begin
    if (merge_overvoltage_into_battery_short_q) begin
      // merged mode: software sees a single short fault
      overvoltage_fault_d = 1'b0; // see (RULE3)
      battery_short_fault_d = overvoltage_fault | battery_short_fault;
    end else begin
      overvoltage_fault_d = overvoltage_fault;
      battery_short_fault_d = battery_short_fault;
    end
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overvoltage_fault_q <= 1'b0;
      battery_short_fault_q <= 1'b0;
    end else begin
      overvoltage_fault_q <= overvoltage_fault_d;
      battery_short_fault_q <= battery_short_fault_d;
    end
  end

  // ==========================================
  // result strobes
  // a disabled battery channel keeps its last result
  wire bat_strobe;
  wire bias_strobe;
  wire in1p_strobe;
  wire in1n_strobe;
  assign bat_strobe = result_valid && (result_source == SRC_BAT) &&
    battery_active_d; // see (RULE9)
  assign bias_strobe = result_valid && (result_source == SRC_BIAS);
  assign in1p_strobe = result_valid && (result_source == SRC_IN1P);
  assign in1n_strobe = result_valid && (result_source == SRC_IN1N);

  // ==========================================
  // result pairs
  wire [7:0] bat_upper;
  wire [7:0] bat_lower;
  wire [7:0] bias_upper;
  wire [7:0] bias_lower;
  wire [7:0] in1p_upper;
  wire [7:0] in1p_lower;
  wire [7:0] in1n_upper;
  wire [7:0] in1n_lower;

  dmr_result_pair #(
    .SOURCE_ID(`DMR_ID_BAT)
  ) u_bat (
    .clk(clk),
    .rst_b(rst_b),
    .result_valid(bat_strobe),
    .result_data(result_data),
    .upper_byte(bat_upper),
    .lower_byte(bat_lower)
  );

  dmr_result_pair #(
    .SOURCE_ID(`DMR_ID_BIAS)
  ) u_bias (
    .clk(clk),
    .rst_b(rst_b),
    .result_valid(bias_strobe),
    .result_data(result_data),
    .upper_byte(bias_upper),
    .lower_byte(bias_lower)
  );

  dmr_result_pair #(
    .SOURCE_ID(`DMR_ID_IN1P)
  ) u_in1p (
    .clk(clk),
    .rst_b(rst_b),
    .result_valid(in1p_strobe),
    .result_data(result_data),
    .upper_byte(in1p_upper),
    .lower_byte(in1p_lower)
  );

  dmr_result_pair #(
    .SOURCE_ID(`DMR_ID_IN1N)
  ) u_in1n ( // see (RULE8)
    .clk(clk),
    .rst_b(rst_b),
    .result_valid(in1n_strobe),
    .result_data(result_data),
    .upper_byte(in1n_upper),
    .lower_byte(in1n_lower)
  );

  // ==========================================
  // read port
  // unmapped offsets read as zero
  reg [7:0] rd_d;
  always @* begin
    case (reg_addr)
      `DMR_CFG_ADDR: rd_d = cfg_read;
      `DMR_BAT_HIGH_ADDR: rd_d = bat_upper;
      `DMR_BAT_LOW_ADDR: rd_d = bat_lower;
      `DMR_BIAS_HIGH_ADDR: rd_d = bias_upper;
      `DMR_BIAS_LOW_ADDR: rd_d = bias_lower;
      `DMR_IN1P_HIGH_ADDR: rd_d = in1p_upper;
      `DMR_IN1P_LOW_ADDR: rd_d = in1p_lower;
      `DMR_IN1N_HIGH_ADDR: rd_d = in1n_upper;
      `DMR_IN1N_LOW_ADDR: rd_d = in1n_lower;
      default: rd_d = 8'h00;
    endcase
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rd_data_q <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rd_data_q <= rd_d;
    end
  end
endmodule

/* hw/dmr_result_pair.v */
// one source's result register pair, updated atomically
// assumes result_valid is a one-cycle strobe on clk with stable data
`timescale 1ns/100ps
module dmr_result_pair #(
  parameter [3:0] SOURCE_ID = 4'h0
) (
  input wire clk,
  input wire rst_b,
  input wire result_valid,
  input wire [11:0] result_data,
  output wire [7:0] upper_byte,
  output wire [7:0] lower_byte
);
  // ==========================================
  // storage
  reg [11:0] value_q;
  // both halves share one register so they always change in the same cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      value_q <= 12'h000;
    end else if (result_valid) begin
      value_q <= result_data; // see (RULE10)
    end
  end
  assign upper_byte = value_q[11:4]; // see (RULE4)
  assign lower_byte = {value_q[3:0], SOURCE_ID}; // see (RULE5) see (RULE6)
endmodule

/* include/dmr_defines.vh */
// constants for the diagnostic monitor result block
// assumes a byte-wide register port addressed by 8-bit offsets
`ifndef DMR_DEFINES_VH
`define DMR_DEFINES_VH
// ==========================================
// register offsets
`define DMR_CFG_ADDR 8'h54
`define DMR_BAT_HIGH_ADDR 8'h56
`define DMR_BAT_LOW_ADDR 8'h57
`define DMR_BIAS_HIGH_ADDR 8'h58
`define DMR_BIAS_LOW_ADDR 8'h59
`define DMR_IN1P_HIGH_ADDR 8'h5a
`define DMR_IN1P_LOW_ADDR 8'h5b
`define DMR_IN1N_HIGH_ADDR 8'h5c
`define DMR_IN1N_LOW_ADDR 8'h5d
// ==========================================
// configuration fields and reset
`define DMR_CFG_RESET 8'h48
`define DMR_CFG_WMASK 8'h6d
`define DMR_SUP_FILT_HI 6
`define DMR_SUP_FILT_LO 5
`define DMR_BAT_FILT_HI 3
`define DMR_BAT_FILT_LO 2
`define DMR_MERGE_BIT 0
// ==========================================
// filter codes and source identifiers
`define DMR_FILT_3M5 2'h0
`define DMR_FILT_200K 2'h1
`define DMR_FILT_100K 2'h2
`define DMR_FILT_NONE 2'h3
`define DMR_ID_BAT 4'h0
`define DMR_ID_BIAS 4'h1
`define DMR_ID_IN1P 4'h2
`define DMR_ID_IN1N 4'h3
`endif
